// *** design/mmdp_consts.svh ***
// constants and behaviour summary for the memory map decode and protect block
// Behaviour
// R01: the 512-byte eeprom decodes at b600-b7ff only while eeprom_enable_bit is one.
// R02: an erased configuration byte of 0f brings eeprom and rom on and the watchdog off.
// R03: the working configuration keeps only its low four bits and reads zero above.
// R04: in normal modes protected bits take one write, and only in the first 64 bus cycles.
// R05: in special modes the time window and the write-once limit are both bypassed.
// R06: software leaving special mode writes protected registers before clearing the mode bit.
// R07: ram_page_field gives the top hex digit of the 256-byte ram base and resets to zero.
// R08: regblock_page_field gives the top hex digit of the 64-byte block base, reset one.
// R09: on a read of any internal resource the external data pins are ignored.
// R10: on overlap only the highest resource is enabled: registers over ram over rom.
// R11: unused register offsets still win priority and read the undriven internal bus.
// R12: in expanded modes block offsets two to seven go external, internal ram and rom off.
// R13: reads return the working copy, loaded from the nonvolatile byte during every reset.
// R14: special_variant_bit accepts a write of zero but never a write back to one.
// R15: the 8K-byte rom decodes at e000-ffff only while rom_enable_bit is one; the code also decodes it whenever neither expanded nor special mode is set.
// R16: a bus cycle counter and a written flag, cleared by reset, enforce the protection.
`ifndef MMDP_CONSTS_SVH
`define MMDP_CONSTS_SVH
`define MMDP_OFF_MAP 12'h000
`define MMDP_OFF_CFG 12'h004
`define MMDP_OFF_MODE 12'h008
`define MMDP_OFF_STAT 12'h00c
`define MMDP_MAP_RESET 8'h01
`define MMDP_CFG_ERASED 8'h0f
`define MMDP_CFG_MASK 8'h0f
`define MMDP_BIT_EEPROM_ENABLE_BIT 0
`define MMDP_BIT_ROM_ENABLE_BIT 1
`define MMDP_WINDOW 7'h40
`define MMDP_EE_BASE 7'h5b
`define MMDP_ROM_BASE 3'h7
`define MMDP_EXT_LO 6'h02
`define MMDP_EXT_HI 6'h07
`endif

// *** design/mmdp_pkg.sv ***
// types of the memory map decode and protect block
package mmdp_pkg;
   typedef enum logic [1:0] {MMDP_IDLE, MMDP_WAIT, MMDP_DONE} mmdp_apb_t;
   typedef struct packed {
      logic sel_regs;
      logic sel_ram;
      logic sel_rom;
      logic sel_eeprom;
      logic sel_ext;
      logic ignore_ext_data;
   } mmdp_sel_t;
   typedef struct packed {
      mmdp_apb_t apb;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] map;
      logic [7:0] cfg;
      logic special;
      logic written;
      logic [6:0] cycles;
      mmdp_sel_t sel;
   } mmdp_st_t;
endpackage : mmdp_pkg

// *** design/mmdp_decode.sv ***
// address decode, priority and protection of the on-chip memory map
`timescale 1ns/1ps
`include "mmdp_consts.svh"
module mmdp_decode
   import mmdp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] nv_config_byte,
   input wire logic special_mode_pin,
   input wire logic expanded_mode,
   input wire logic bus_cycle,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_rd,
   output mmdp_sel_t cpu_sel
);
   mmdp_st_t st_r;
   mmdp_st_t st_nxt;
   logic reg_hit;
   logic reg_ext;
   logic ram_hit;
   logic rom_hit;
   logic ee_hit;
   logic prot_ok;
   logic acc;

   function automatic logic page_hit(input logic [15:0] a, input logic [3:0] pg,
      input logic [3:0] span);
      page_hit = (a[15:12] == pg) && ((a[11:8] & span) == 4'h0);
   endfunction : page_hit

   always_comb
   begin
      st_nxt = st_r;
      reg_hit = page_hit(cpu_addr, st_r.map[3:0], 4'hf) && (cpu_addr[7:6] == 2'b00);
      // port replacement offsets go out to the external device
      reg_ext = expanded_mode && reg_hit && (cpu_addr[5:0] >= `MMDP_EXT_LO)
         && (cpu_addr[5:0] <= `MMDP_EXT_HI); // R12
      ram_hit = page_hit(cpu_addr, st_r.map[7:4], 4'hf);
      // normal single-chip mode needs a reset vector, so rom is forced on there
      rom_hit = (st_r.cfg[`MMDP_BIT_ROM_ENABLE_BIT] || (!expanded_mode && !st_r.special))
         && (cpu_addr[15:13] == `MMDP_ROM_BASE); // R15
      ee_hit = st_r.cfg[`MMDP_BIT_EEPROM_ENABLE_BIT] && (cpu_addr[15:9] == `MMDP_EE_BASE); // R01
      st_nxt.sel.sel_regs = reg_hit; // R10 R11
      st_nxt.sel.sel_ram = ram_hit && !reg_hit; // R10 R12
      st_nxt.sel.sel_rom = rom_hit && !reg_hit && !ram_hit; // R10 R12
      st_nxt.sel.sel_eeprom = ee_hit && !reg_hit && !ram_hit && !rom_hit;
      st_nxt.sel.sel_ext = reg_ext || !(reg_hit || ram_hit || rom_hit || ee_hit);
      st_nxt.sel.ignore_ext_data = cpu_rd && !st_nxt.sel.sel_ext; // R09 R11
      // counter saturates so the window stays shut until the next reset
      if (bus_cycle && (st_r.cycles != `MMDP_WINDOW))
      begin
         st_nxt.cycles = st_r.cycles + 7'h01; // R16
      end
      prot_ok = st_r.special || ((st_r.cycles != `MMDP_WINDOW) && !st_r.written); // R04 R05
      acc = psel && penable;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      unique case (st_r.apb)
         MMDP_IDLE:
         begin
            if (acc)
            begin
               st_nxt.apb = MMDP_WAIT;
            end
         end
         MMDP_WAIT:
         begin
            st_nxt.apb = MMDP_DONE;
            st_nxt.pready = 1'b1;
            st_nxt.prdata = 32'h0000_0000;
            unique case (paddr)
               `MMDP_OFF_MAP: st_nxt.prdata[7:0] = st_r.map;
               `MMDP_OFF_CFG: st_nxt.prdata[7:0] = st_r.cfg & `MMDP_CFG_MASK; // R03 R13
               `MMDP_OFF_MODE: st_nxt.prdata[0] = st_r.special;
               `MMDP_OFF_STAT: st_nxt.prdata[8:0] = {prot_ok, st_r.written, st_r.cycles};
               default: st_nxt.pslverr = 1'b1;
            endcase
         end
         MMDP_DONE:
         begin
            st_nxt.apb = MMDP_IDLE;
            if (acc && pwrite && !st_r.pslverr)
            begin
               if ((paddr == `MMDP_OFF_MAP) && prot_ok)
               begin
                  st_nxt.map = pwdata[7:0]; // R07 R08 R04
                  st_nxt.written = 1'b1; // R16
               end
               // a one never returns the block to special mode
               if ((paddr == `MMDP_OFF_MODE) && !pwdata[0])
               begin
                  st_nxt.special = 1'b0; // R14 R06
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
         st_r.apb <= MMDP_IDLE;
         st_r.map <= `MMDP_MAP_RESET; // R07 R08
         st_r.cfg <= nv_config_byte & `MMDP_CFG_MASK; // R13 R02 R03
         st_r.special <= special_mode_pin;
         st_r.sel.sel_ext <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign cpu_sel = st_r.sel;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_cfg_upper_zero: assert property (st_r.cfg[7:4] == 4'h0) // R03
      else $error("configuration upper bits not zero");
   a_window_closed: assert property ((!st_r.special && st_r.cycles == `MMDP_WINDOW
      && st_r.apb == MMDP_DONE) |=> $stable(st_r.map)) // R04
      else $error("map written after window");
   a_write_once: assert property ((!st_r.special && st_r.written) |=> $stable(st_r.map)) // R04
      else $error("map written twice");
   a_mode_no_set: assert property (!st_r.special |=> !st_r.special) // R14
      else $error("special mode re-entered");
   a_reg_over_ram: assert property ((reg_hit) |=> (cpu_sel.sel_regs && !cpu_sel.sel_ram
      && !cpu_sel.sel_rom)) // R10
      else $error("register block lost priority");
   a_ram_over_rom: assert property ((ram_hit && !reg_hit) |=> !cpu_sel.sel_rom) // R10
      else $error("rom enabled over ram");
   a_ignore_pins: assert property ((cpu_rd && (ram_hit || reg_hit) && !reg_ext)
      |=> cpu_sel.ignore_ext_data) // R09
      else $error("external data not ignored");
   a_port_ext: assert property (reg_ext |=> (cpu_sel.sel_ext && !cpu_sel.sel_ram
      && !cpu_sel.sel_rom)) // R12
      else $error("replacement offset not external");
   a_ee_off: assert property (!st_r.cfg[`MMDP_BIT_EEPROM_ENABLE_BIT] |=> !cpu_sel.sel_eeprom) // R01
      else $error("eeprom decoded while disabled");
   a_apb_answer: assert property ((psel && penable && st_r.apb == MMDP_IDLE)
      |=> ##1 pready) // R13
      else $error("apb answer late");

   a_pready_pulse: assert property (pready |=> !pready) // R13
      else $error("pready held past one cycle");

   a_err_with_ready: assert property (pslverr |-> pready) // R13
      else $error("pslverr without pready");

   a_bad_offset: assert property ((st_r.apb == MMDP_WAIT
      && !(paddr inside {`MMDP_OFF_MAP, `MMDP_OFF_CFG, `MMDP_OFF_MODE, `MMDP_OFF_STAT}))
      |=> (pready && pslverr)) // R13
      else $error("unmapped offset not refused");

   a_map_after_reset: assert property ($rose(rst_n) |-> (st_r.map == `MMDP_MAP_RESET
      && st_r.cycles == 7'h00 && !st_r.written)) // R07
      else $error("map or counter not at reset value");

   a_cfg_loaded: assert property ($rose(rst_n)
      |-> (st_r.cfg == ($past(nv_config_byte) & `MMDP_CFG_MASK))) // R13
      else $error("configuration not loaded in reset");

   // working copy only changes in reset, never by a bus write
   a_cfg_stable: assert property (1'b1 |=> $stable(st_r.cfg)) // R13
      else $error("configuration changed while running");

   a_cycles_ceiling: assert property (st_r.cycles <= `MMDP_WINDOW) // R16
      else $error("bus cycle counter past window");

   a_cycles_count: assert property ((bus_cycle && st_r.cycles != `MMDP_WINDOW)
      |=> (st_r.cycles == $past(st_r.cycles) + 7'h01)) // R16
      else $error("bus cycle not counted");

   a_cycles_hold: assert property (!bus_cycle |=> $stable(st_r.cycles)) // R16
      else $error("counter moved without bus cycle");

   a_map_in_window: assert property ((!st_r.special && !st_r.written
      && st_r.cycles != `MMDP_WINDOW && st_r.apb == MMDP_DONE && acc && pwrite
      && paddr == `MMDP_OFF_MAP) |=> (st_r.map == $past(pwdata[7:0]) && st_r.written)) // R04
      else $error("map write in window lost");

   a_map_special: assert property ((st_r.special && st_r.apb == MMDP_DONE && acc && pwrite
      && paddr == `MMDP_OFF_MAP) |=> (st_r.map == $past(pwdata[7:0]))) // R05
      else $error("map write in special mode lost");

   a_mode_clear: assert property ((st_r.apb == MMDP_DONE && acc && pwrite
      && paddr == `MMDP_OFF_MODE && !pwdata[0]) |=> !st_r.special) // R14
      else $error("special mode not left");

   a_ram_select: assert property ((ram_hit && !reg_hit) |=> cpu_sel.sel_ram) // R07
      else $error("ram not selected on its page");

   a_rom_off: assert property ((!st_r.cfg[`MMDP_BIT_ROM_ENABLE_BIT] && (expanded_mode || st_r.special))
      |=> !cpu_sel.sel_rom) // R15
      else $error("rom decoded while disabled");

   a_no_hit_ext: assert property ((!reg_hit && !ram_hit && !rom_hit && !ee_hit)
      |=> cpu_sel.sel_ext) // R09
      else $error("unclaimed address not external");

   a_ext_pins_used: assert property (cpu_sel.sel_ext |-> !cpu_sel.ignore_ext_data) // R09
      else $error("external data ignored on external access");

   a_single_memory: assert property ($onehot0({cpu_sel.sel_regs, cpu_sel.sel_ram,
      cpu_sel.sel_rom, cpu_sel.sel_eeprom})) // R10
      else $error("two internal resources selected");

   c_port_ext: cover property (reg_ext);

   c_remap: cover property (st_r.apb == MMDP_DONE && psel && pwrite && paddr == `MMDP_OFF_MAP);
   c_overlap: cover property (reg_hit && ram_hit && rom_hit);
   c_leave_special: cover property (st_r.special ##1 !st_r.special);
   c_window_shut: cover property (st_r.cycles == `MMDP_WINDOW);
endmodule : mmdp_decode

// *** sim/mmdp_cpu_model.sv ***
// cpu side model: bus cycle strobe and registered cpu address
`timescale 1ns/1ps
module mmdp_cpu_model
   import mmdp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [15:0] req_addr,
   input wire logic req_rd,
   output logic bus_cycle,
   output logic [15:0] cpu_addr,
   output logic cpu_rd
);
   logic [1:0] div_r;
   // one bus cycle every four mclk, quiet in reset
   always_ff @(posedge mclk)
   begin
      div_r <= rst_n ? div_r + 2'h1 : 2'h0;
      bus_cycle <= rst_n && (div_r == 2'h3);
      cpu_addr <= req_addr;
      cpu_rd <= req_rd;
   end
endmodule : mmdp_cpu_model

// *** sim/memory_map_decode_protect_test.sv ***
// self-checking bench of the memory map decode and protect block
`timescale 1ns/1ps
module memory_map_decode_protect_test
   import mmdp_pkg::*;
;
   logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic expanded_mode = 0, special_mode_pin = 0, bus_cycle, cpu_rd, req_rd = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic [7:0] nv_config_byte = 8'hff, m;
   logic [3:0] c;
   logic [15:0] cpu_addr, req_addr = 16'h0000;
   logic [15:0] tbl [7] = '{16'hf035, 16'hf040, 16'he000, 16'hb6ff, 16'hb800, 16'h1005, 16'hf003};
   mmdp_sel_t cpu_sel;
   int num_errors = 0, n_compared = 0, cyc = 0, seed = 92534;
   mmdp_decode dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .nv_config_byte(nv_config_byte), .special_mode_pin(special_mode_pin),
      .expanded_mode(expanded_mode), .bus_cycle(bus_cycle), .cpu_addr(cpu_addr),
      .cpu_rd(cpu_rd), .cpu_sel(cpu_sel));
   mmdp_cpu_model cpu (.mclk(mclk), .rst_n(rst_n), .req_addr(req_addr), .req_rd(req_rd),
      .bus_cycle(bus_cycle), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd));
   initial
   begin
      forever #2 mclk = ~mclk;
   end
   function automatic mmdp_sel_t exp_sel(input logic [15:0] a, input logic rd);
      mmdp_sel_t s;
      s = '0;
      s.sel_regs = (a[15:12] == m[3:0]) && (a[11:6] == 6'h00);
      s.sel_ext = s.sel_regs && expanded_mode && (a[5:0] >= 6'h02) && (a[5:0] <= 6'h07);
      s.sel_ram = !s.sel_regs && (a[15:12] == m[7:4]) && (a[11:8] == 4'h0);
      s.sel_rom = !s.sel_regs && !s.sel_ram && (&a[15:13])
         && (c[1] || (!expanded_mode && !special_mode_pin));
      s.sel_eeprom = !s.sel_regs && !s.sel_ram && !s.sel_rom && c[0] && (a[15:9] == 7'h5b);
      if (!(s.sel_regs || s.sel_ram || s.sel_rom || s.sel_eeprom))
         s.sel_ext = 1'b1;
      s.ignore_ext_data = rd && !s.sel_ext;
      return s;
   endfunction : exp_sel
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x)
      begin
         $display("Error %s expected %h seen %h", n, x, g);
         num_errors++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      t = 0;
      do begin @(posedge mclk); t++; end while (pready !== 1'b1 && t < 20);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      chk("pready", 1, t < 20);
   endtask : apb
   task automatic rst(input logic [7:0] nv, input logic sp);
      @(posedge mclk);
      rst_n <= 0;
      nv_config_byte <= nv;
      special_mode_pin <= sp;
      repeat (2) @(posedge mclk);
      rst_n <= 1;
   endtask : rst
   // table corners first, then random addresses over the whole map
   task automatic decode;
      logic [15:0] a;
      for (int k = 0; k < 15; k++)
      begin
         a = (k < 7) ? tbl[k] : 16'($random(seed));
         @(posedge mclk);
         req_addr <= a;
         req_rd <= k[0];
         repeat (2) @(posedge mclk);
         #1 chk("cpu_sel", 32'(exp_sel(a, k[0])), 32'(cpu_sel));
      end
   endtask : decode
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         results();
      end
   end
   initial
   begin
      rst(8'hff, 0);
      m = 8'h01;
      c = 4'hf;
      apb(0, 12'h000, 0);
      chk("map", 32'h0000_0001, q);
      apb(0, 12'h004, 0);
      chk("cfg", 32'h0000_000f, q);
      apb(0, 12'h010, 0);
      chk("pslverr", 1, e);
      decode();
      apb(1, 12'h000, 32'h0000_00ff);
      apb(1, 12'h000, 32'h0000_0023);
      apb(0, 12'h000, 0);
      chk("map", 32'h0000_00ff, q);
      m = 8'hff;
      decode();
      expanded_mode <= 1;
      decode();
      $display("normal mode test done");
      rst(8'h0e, 1);
      m = 8'h01;
      c = 4'he;
      decode();
      apb(1, 12'h000, 32'h0000_0023);
      apb(1, 12'h000, 32'h0000_0045);
      apb(0, 12'h000, 0);
      chk("map", 32'h0000_0045, q);
      // protected writes go in before leaving special mode
      apb(1, 12'h008, 0);
      apb(1, 12'h008, 1);
      apb(0, 12'h008, 0);
      chk("mode", 0, q);
      repeat (300) @(posedge mclk);
      apb(1, 12'h000, 32'h0000_0067);
      apb(0, 12'h000, 0);
      chk("map", 32'h0000_0045, q);
      apb(0, 12'h00c, 0);
      chk("cycles", 32'h0000_0040, {25'h0, q[6:0]});
      $display("special mode test done");
      results();
   end
endmodule : memory_map_decode_protect_test
